// ---- hw/rxcfg_regs.sv ----
// Purpose: receiver threshold, boost override, equalizer mode and routing registers
// Assumes: decoded byte access from the management serial port, synchronous to clk_i
// Notes:   every control output is registered behind storage, so it follows a write by two cycles
//
// What this block does
// - first input thresholds from 0x14 bits 5:4, 3:2
// - second input thresholds, same bits, at 0x15
// - decode 0000/0101/1010/1111 to threshold levels
// - bit 3 enables boost override, reset 0x88
// - mode 00 at 0x31 runs manual equalizer
// - mode 01 selects test; others invalid
// - route 00/01 picks first input, outputs
// - route 10/11 picks second input, outputs
// - override applies boost register 0x03 to stages
`include "rxcfg_cfg.svh"

module rxcfg_regs
   import rxcfg_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
) (
   input  wire logic              clk_i,                    // 40 MHz register clock
   input  wire logic              reset_i,                  // synchronous, active high
   input  wire logic [ADDR_W-1:0] reg_addr_i,               // register offset
   input  wire logic [DATA_W-1:0] reg_wdata_i,              // write data
   input  wire logic              reg_wr_i,                 // write strobe, one cycle
   input  wire logic              reg_rd_i,                 // read strobe, one cycle
   input  wire logic [DATA_W-1:0] eq_adapt_boost_i,         // boost from adaptation
   output logic [DATA_W-1:0]      reg_rdata_o,              // read data
   output logic                   reg_rvalid_o,             // read data valid pulse
   output logic [1:0]             first_input_assert_level_select_o,    // raw assert pair
   output logic [1:0]             first_input_deassert_level_select_o,  // raw de-assert pair
   output logic [1:0]             second_input_assert_level_select_o,   // raw assert pair
   output logic [1:0]             second_input_deassert_level_select_o, // raw de-assert pair
   output rxcfg_level_t           first_input_level_o,      // decoded threshold level
   output rxcfg_level_t           second_input_level_o,     // decoded threshold level
   output logic                   boost_override_enable_o,  // override active
   output logic [DATA_W-1:0]      eq_stage_boost_o,         // boost to the four stages
   output rxcfg_eq_mode_t         eq_mode_o,                // equalizer mode
   output logic                   eq_test_mode_o,           // test mode active
   output logic                   eq_mode_invalid_o,        // illegal mode code held
   output logic                   input_output_route_select_o, // 0 first, 1 second input
   output logic                   first_serial_output_en_o, // first output driven
   output logic                   second_serial_output_en_o // second output driven
);

   // decoded threshold level from the four-bit assert/de-assert code
   function automatic rxcfg_level_t level_decode(input logic [3:0] code);
      rxcfg_level_t lvl;
      lvl = RXCFG_LVL_UNDEFINED;
      case (code)
         `RXCFG_THR_NOMINAL: lvl = RXCFG_LVL_NOMINAL;
         `RXCFG_THR_MINUS2:  lvl = RXCFG_LVL_MINUS2;
         `RXCFG_THR_PLUS5:   lvl = RXCFG_LVL_PLUS5;
         `RXCFG_THR_PLUS3:   lvl = RXCFG_LVL_PLUS3;
         default:            lvl = RXCFG_LVL_UNDEFINED;
      endcase
      return lvl;
   endfunction

   // register storage; reserved bits are plain read-write cells
   logic [DATA_W-1:0] boost_q;
   logic [DATA_W-1:0] thr0_q;
   logic [DATA_W-1:0] thr1_q;
   logic [DATA_W-1:0] boost_ovr_q;
   logic [DATA_W-1:0] mode_route_q;

   // address decode
   wire logic hit_boost      = (reg_addr_i == ADDR_W'(`RXCFG_OFS_BOOST));
   wire logic hit_thr0       = (reg_addr_i == ADDR_W'(`RXCFG_OFS_THR0));
   wire logic hit_thr1       = (reg_addr_i == ADDR_W'(`RXCFG_OFS_THR1));
   wire logic hit_boost_ovr  = (reg_addr_i == ADDR_W'(`RXCFG_OFS_BOOST_OVR));
   wire logic hit_mode_route = (reg_addr_i == ADDR_W'(`RXCFG_OFS_MODE_ROUTE));

   wire logic wr_boost      = reg_wr_i & hit_boost;
   wire logic wr_thr0       = reg_wr_i & hit_thr0;
   wire logic wr_thr1       = reg_wr_i & hit_thr1;
   wire logic wr_boost_ovr  = reg_wr_i & hit_boost_ovr;
   wire logic wr_mode_route = reg_wr_i & hit_mode_route;

   // read mux; unmapped offsets read as zero
   wire logic [DATA_W-1:0] rdata_d =
      hit_boost      ? boost_q      :
      hit_thr0       ? thr0_q       :
      hit_thr1       ? thr1_q       :
      hit_boost_ovr  ? boost_ovr_q  :
      hit_mode_route ? mode_route_q :
                       DATA_W'(`RXCFG_RD_UNMAPPED);

   // storage next values
   wire logic [DATA_W-1:0] boost_d      = wr_boost      ? reg_wdata_i : boost_q;
   wire logic [DATA_W-1:0] thr0_d       = wr_thr0       ? reg_wdata_i : thr0_q;
   wire logic [DATA_W-1:0] thr1_d       = wr_thr1       ? reg_wdata_i : thr1_q;
   wire logic [DATA_W-1:0] boost_ovr_d  = wr_boost_ovr  ? reg_wdata_i : boost_ovr_q;
   wire logic [DATA_W-1:0] mode_route_d = wr_mode_route ? reg_wdata_i : mode_route_q;

   // field pickers and decoders, shared by the run path and the reset path
   function automatic logic [1:0] assert_pair(input logic [DATA_W-1:0] thr);
      return thr[`RXCFG_THR_ASSERT_MSB:`RXCFG_THR_ASSERT_LSB];
   endfunction

   function automatic logic [1:0] deassert_pair(input logic [DATA_W-1:0] thr);
      return thr[`RXCFG_THR_DEASSERT_MSB:`RXCFG_THR_DEASSERT_LSB];
   endfunction

   function automatic logic [1:0] mode_field(input logic [DATA_W-1:0] mr);
      return mr[`RXCFG_MODE_MSB:`RXCFG_MODE_LSB];
   endfunction

   function automatic logic [1:0] route_field(input logic [DATA_W-1:0] mr);
      return mr[`RXCFG_ROUTE_MSB:`RXCFG_ROUTE_LSB];
   endfunction

   // illegal codes are flagged, never mapped onto a legal mode
   function automatic rxcfg_eq_mode_t mode_decode(input logic [1:0] code);
      rxcfg_eq_mode_t md;
      md = RXCFG_EQ_INVALID;
      case (code)
         `RXCFG_MODE_MANUAL: md = RXCFG_EQ_MANUAL;
         `RXCFG_MODE_TEST:   md = RXCFG_EQ_TEST;
         default:            md = RXCFG_EQ_INVALID;
      endcase
      return md;
   endfunction

   function automatic logic route_second(input logic [1:0] rt);
      return (rt == `RXCFG_ROUTE_IN1_SECOND_SERIAL_OUTPUT) | (rt == `RXCFG_ROUTE_IN1_BOTH);
   endfunction

   function automatic logic route_first_serial_output(input logic [1:0] rt);
      return (rt == `RXCFG_ROUTE_IN0_BOTH) | (rt == `RXCFG_ROUTE_IN0_FIRST_SERIAL_OUTPUT) |
             (rt == `RXCFG_ROUTE_IN1_BOTH);
   endfunction

   function automatic logic route_second_serial_output(input logic [1:0] rt);
      return (rt == `RXCFG_ROUTE_IN0_BOTH) | (rt == `RXCFG_ROUTE_IN1_SECOND_SERIAL_OUTPUT) |
             (rt == `RXCFG_ROUTE_IN1_BOTH);
   endfunction

   // output reset values come from the register reset values so the two cannot drift apart
   localparam logic [DATA_W-1:0] THR0_RST       = DATA_W'(`RXCFG_RST_THR0);
   localparam logic [DATA_W-1:0] THR1_RST       = DATA_W'(`RXCFG_RST_THR1);
   localparam logic [DATA_W-1:0] BOOST_RST      = DATA_W'(`RXCFG_RST_BOOST);
   localparam logic [DATA_W-1:0] BOOST_OVR_RST  = DATA_W'(`RXCFG_RST_BOOST_OVR);
   localparam logic [DATA_W-1:0] MODE_ROUTE_RST = DATA_W'(`RXCFG_RST_MODE_ROUTE);

   wire logic [1:0]     rst_thr0_assert   = assert_pair(THR0_RST);
   wire logic [1:0]     rst_thr0_deassert = deassert_pair(THR0_RST);
   wire logic [1:0]     rst_thr1_assert   = assert_pair(THR1_RST);
   wire logic [1:0]     rst_thr1_deassert = deassert_pair(THR1_RST);
   wire rxcfg_eq_mode_t rst_mode          = mode_decode(mode_field(MODE_ROUTE_RST));
   wire logic [1:0]     rst_route         = route_field(MODE_ROUTE_RST);

   // field extraction from held values
   wire logic [1:0] thr0_assert   = assert_pair(thr0_q);
   wire logic [1:0] thr0_deassert = deassert_pair(thr0_q);
   wire logic [1:0] thr1_assert   = assert_pair(thr1_q);
   wire logic [1:0] thr1_deassert = deassert_pair(thr1_q);

   wire rxcfg_level_t lvl0_d = level_decode({thr0_assert, thr0_deassert});
   wire rxcfg_level_t lvl1_d = level_decode({thr1_assert, thr1_deassert});

   wire logic ovr_en_d = boost_ovr_q[`RXCFG_OVR_EN_BIT];

   // override forces the stored boost, otherwise adaptation drives the stages
   wire logic [DATA_W-1:0] stage_boost_d = ovr_en_d ? boost_q : eq_adapt_boost_i;

   wire logic [1:0]     mode_code = mode_field(mode_route_q);
   wire rxcfg_eq_mode_t mode_d    = mode_decode(mode_code);
   wire logic           mode_test = (mode_d == RXCFG_EQ_TEST);
   wire logic           mode_bad  = (mode_d == RXCFG_EQ_INVALID);

   wire logic [1:0] route       = route_field(mode_route_q);
   wire logic       route_sel_d = route_second(route);
   wire logic       first_serial_output_en_d   = route_first_serial_output(route);
   wire logic       second_serial_output_en_d   = route_second_serial_output(route);

   // storage
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         boost_q      <= DATA_W'(`RXCFG_RST_BOOST);
         thr0_q       <= DATA_W'(`RXCFG_RST_THR0);
         thr1_q       <= DATA_W'(`RXCFG_RST_THR1);
         boost_ovr_q  <= DATA_W'(`RXCFG_RST_BOOST_OVR);
         mode_route_q <= DATA_W'(`RXCFG_RST_MODE_ROUTE);
      end else begin
         boost_q      <= boost_d;
         thr0_q       <= thr0_d;
         thr1_q       <= thr1_d;
         boost_ovr_q  <= boost_ovr_d;
         mode_route_q <= mode_route_d;
      end
   end

   // read port; data reflects contents before a same-cycle write
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         reg_rdata_o  <= DATA_W'(`RXCFG_RD_UNMAPPED);
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rdata_o  <= reg_rd_i ? rdata_d : reg_rdata_o;
         reg_rvalid_o <= reg_rd_i;
      end
   end

   // control outputs, one cycle behind storage so each is a flip-flop
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         first_input_assert_level_select_o    <= rst_thr0_assert;
         first_input_deassert_level_select_o  <= rst_thr0_deassert;
         second_input_assert_level_select_o   <= rst_thr1_assert;
         second_input_deassert_level_select_o <= rst_thr1_deassert;
         first_input_level_o                  <= level_decode({rst_thr0_assert, rst_thr0_deassert});
         second_input_level_o                 <= level_decode({rst_thr1_assert, rst_thr1_deassert});
         boost_override_enable_o              <= BOOST_OVR_RST[`RXCFG_OVR_EN_BIT];
         eq_stage_boost_o                     <= BOOST_RST;
         eq_mode_o                            <= rst_mode;
         eq_test_mode_o                       <= (rst_mode == RXCFG_EQ_TEST);
         eq_mode_invalid_o                    <= (rst_mode == RXCFG_EQ_INVALID);
         input_output_route_select_o          <= route_second(rst_route);
         first_serial_output_en_o             <= route_first_serial_output(rst_route);
         second_serial_output_en_o            <= route_second_serial_output(rst_route);
      end else begin
         first_input_assert_level_select_o    <= thr0_assert;
         first_input_deassert_level_select_o  <= thr0_deassert;
         second_input_assert_level_select_o   <= thr1_assert;
         second_input_deassert_level_select_o <= thr1_deassert;
         first_input_level_o                  <= lvl0_d;
         second_input_level_o                 <= lvl1_d;
         boost_override_enable_o              <= ovr_en_d;
         eq_stage_boost_o                     <= stage_boost_d;
         eq_mode_o                            <= mode_d;
         eq_test_mode_o                       <= mode_test;
         eq_mode_invalid_o                    <= mode_bad;
         input_output_route_select_o          <= route_sel_d;
         first_serial_output_en_o             <= first_serial_output_en_d;
         second_serial_output_en_o            <= second_serial_output_en_d;
      end
   end

endmodule

// ---- hw/rxcfg_cfg.svh ----
// Purpose: offsets, field positions, reset values and codes of the receiver config bank
// Assumes: 8-bit register space reached through the management serial port
// Notes:   definitions only
`ifndef RXCFG_CFG_SVH
`define RXCFG_CFG_SVH

// register offsets
`define RXCFG_OFS_BOOST        8'h03
`define RXCFG_OFS_THR0         8'h14
`define RXCFG_OFS_THR1         8'h15
`define RXCFG_OFS_BOOST_OVR    8'h2d
`define RXCFG_OFS_MODE_ROUTE   8'h31

// reset values
`define RXCFG_RST_BOOST        8'h80
`define RXCFG_RST_THR0         8'h00
`define RXCFG_RST_THR1         8'h00
`define RXCFG_RST_BOOST_OVR    8'h88
`define RXCFG_RST_MODE_ROUTE   8'h00
`define RXCFG_RD_UNMAPPED      8'h00

// field positions
`define RXCFG_THR_ASSERT_MSB   5
`define RXCFG_THR_ASSERT_LSB   4
`define RXCFG_THR_DEASSERT_MSB 3
`define RXCFG_THR_DEASSERT_LSB 2
`define RXCFG_OVR_EN_BIT       3
`define RXCFG_MODE_MSB         6
`define RXCFG_MODE_LSB         5
`define RXCFG_ROUTE_MSB        1
`define RXCFG_ROUTE_LSB        0

// combined threshold codes, assert pair above de-assert pair
`define RXCFG_THR_NOMINAL      4'h0
`define RXCFG_THR_MINUS2       4'h5
`define RXCFG_THR_PLUS5        4'ha
`define RXCFG_THR_PLUS3        4'hf

// equalizer mode codes
`define RXCFG_MODE_MANUAL      2'h0
`define RXCFG_MODE_TEST        2'h1

// routing codes
`define RXCFG_ROUTE_IN0_BOTH   2'h0
`define RXCFG_ROUTE_IN0_FIRST_SERIAL_OUTPUT   2'h1
`define RXCFG_ROUTE_IN1_SECOND_SERIAL_OUTPUT   2'h2
`define RXCFG_ROUTE_IN1_BOTH   2'h3

`endif

// ---- hw/rxcfg_pkg.sv ----
// Purpose: shared types of the receiver config bank
// Assumes: nothing beyond the cfg header
// Notes:   enums carry no explicit codes
package rxcfg_pkg;

   typedef enum logic [2:0] {
      RXCFG_LVL_NOMINAL,
      RXCFG_LVL_MINUS2,
      RXCFG_LVL_PLUS5,
      RXCFG_LVL_PLUS3,
      RXCFG_LVL_UNDEFINED
   } rxcfg_level_t;

   typedef enum logic [1:0] {
      RXCFG_EQ_MANUAL,
      RXCFG_EQ_TEST,
      RXCFG_EQ_INVALID
   } rxcfg_eq_mode_t;

endpackage

// ---- bench/rxcfg_regs_checker.sv ----
// Purpose: port assertions for rxcfg_regs
// Assumes: one clock, synchronous active-high reset
// Notes:   control outputs follow a write by two edges
module rxcfg_regs_checker
   import rxcfg_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
) (
   input wire logic              clk_i, reset_i, reg_wr_i, reg_rd_i, reg_rvalid_o,   // strobes
   input wire logic [ADDR_W-1:0] reg_addr_i,                                         // offset
   input wire logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o, eq_stage_boost_o,         // bytes
   input wire logic [DATA_W-1:0] eq_adapt_boost_i,                                   // adapted boost
   input wire logic [1:0]        first_input_assert_level_select_o,                  // raw pair
   input wire logic [1:0]        first_input_deassert_level_select_o,                // raw pair
   input wire logic [1:0]        second_input_assert_level_select_o,                 // raw pair
   input wire logic [1:0]        second_input_deassert_level_select_o,               // raw pair
   input rxcfg_level_t           first_input_level_o, second_input_level_o,          // levels
   input rxcfg_eq_mode_t         eq_mode_o,                                          // mode
   input wire logic              boost_override_enable_o, eq_test_mode_o, eq_mode_invalid_o, // flags
   input wire logic              input_output_route_select_o, first_serial_output_en_o, // route
   input wire logic              second_serial_output_en_o                           // route
);
   timeunit 1ns;
   timeprecision 1ps;
   wire [3:0] c0 = {first_input_assert_level_select_o, first_input_deassert_level_select_o};
   wire [3:0] c1 = {second_input_assert_level_select_o, second_input_deassert_level_select_o};
   wire [2:0] rt = {input_output_route_select_o, first_serial_output_en_o, second_serial_output_en_o};
   wire       w03 = reg_wr_i && reg_addr_i == 8'h03;
   wire       w31 = reg_wr_i && reg_addr_i == 8'h31;
   function automatic rxcfg_level_t lvl(input logic [3:0] c);
      return c == 4'h0 ? RXCFG_LVL_NOMINAL : c == 4'h5 ? RXCFG_LVL_MINUS2 :
             c == 4'ha ? RXCFG_LVL_PLUS5 : c == 4'hf ? RXCFG_LVL_PLUS3 : RXCFG_LVL_UNDEFINED;
   endfunction
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_thr0; reg_wr_i && reg_addr_i == 8'h14 |-> ##2 c0 == $past(reg_wdata_i[5:2], 2); endproperty
   a_thr0: assert property (p_thr0) else $error("first threshold wrong");
   property p_thr1; reg_wr_i && reg_addr_i == 8'h15 |-> ##2 c1 == $past(reg_wdata_i[5:2], 2); endproperty
   a_thr1: assert property (p_thr1) else $error("second threshold wrong");
   property p_lvl; first_input_level_o == lvl(c0) && second_input_level_o == lvl(c1); endproperty
   a_lvl: assert property (p_lvl) else $error("level decode wrong");
   property p_ovr; reg_wr_i && reg_addr_i == 8'h2d |-> ##2 boost_override_enable_o == $past(reg_wdata_i[3], 2);
   endproperty
   a_ovr: assert property (p_ovr) else $error("override wrong");
   // stage boost and override flag leave the same edge, so they are compared in one cycle
   property p_adp; !boost_override_enable_o |-> eq_stage_boost_o == $past(eq_adapt_boost_i); endproperty
   a_adp: assert property (p_adp) else $error("adapted boost wrong");
   property p_bst; (w03 ##1 boost_override_enable_o) |=> eq_stage_boost_o == $past(reg_wdata_i, 2); endproperty
   a_bst: assert property (p_bst) else $error("override boost wrong");
   property p_mode; w31 |-> ##2 {eq_test_mode_o, eq_mode_invalid_o} == {$past(reg_wdata_i[6:5], 2) == 2'h1,
      $past(reg_wdata_i[6], 2)}; endproperty
   a_mode: assert property (p_mode) else $error("mode wrong");
   property p_route; w31 |-> ##2 rt == {$past(reg_wdata_i[1], 2), $past(reg_wdata_i[1:0], 2) != 2'h2,
      $past(reg_wdata_i[1:0], 2) != 2'h1}; endproperty
   a_route: assert property (p_route) else $error("route wrong");
   property p_rd; reg_rd_i && reg_addr_i == 8'h31 |=> reg_rvalid_o && reg_rdata_o[1] == rt[2]; endproperty
   a_rd: assert property (p_rd) else $error("route readback wrong");
endmodule

// ---- bench/tb.sv ----
// Purpose: self-checking bench for rxcfg_regs
// Assumes: byte register port, outputs two edges after a write
// Notes:   bench drives every input itself
module tb
   import rxcfg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_rvalid_o;
   logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, eq_adapt_boost_i = 8'h3c, reg_rdata_o, eq_stage_boost_o;
   logic [1:0] first_input_assert_level_select_o, first_input_deassert_level_select_o;
   logic [1:0] second_input_assert_level_select_o, second_input_deassert_level_select_o;
   rxcfg_level_t first_input_level_o, second_input_level_o;
   rxcfg_eq_mode_t eq_mode_o;
   logic boost_override_enable_o, eq_test_mode_o, eq_mode_invalid_o;
   logic input_output_route_select_o, first_serial_output_en_o, second_serial_output_en_o;
   int n_errors = 0, check_count = 0;
   wire [2:0] rt = {input_output_route_select_o, first_serial_output_en_o, second_serial_output_en_o};
   always #12.5 clk_i = ~clk_i;
   rxcfg_regs i_rxcfg_regs (
      .clk_i                                (clk_i),
      .reset_i                              (reset_i),
      .reg_addr_i                           (reg_addr_i),
      .reg_wdata_i                          (reg_wdata_i),
      .reg_wr_i                             (reg_wr_i),
      .reg_rd_i                             (reg_rd_i),
      .eq_adapt_boost_i                     (eq_adapt_boost_i),
      .reg_rdata_o                          (reg_rdata_o),
      .reg_rvalid_o                         (reg_rvalid_o),
      .first_input_assert_level_select_o    (first_input_assert_level_select_o),
      .first_input_deassert_level_select_o  (first_input_deassert_level_select_o),
      .second_input_assert_level_select_o   (second_input_assert_level_select_o),
      .second_input_deassert_level_select_o (second_input_deassert_level_select_o),
      .first_input_level_o                  (first_input_level_o),
      .second_input_level_o                 (second_input_level_o),
      .boost_override_enable_o              (boost_override_enable_o),
      .eq_stage_boost_o                     (eq_stage_boost_o),
      .eq_mode_o                            (eq_mode_o),
      .eq_test_mode_o                       (eq_test_mode_o),
      .eq_mode_invalid_o                    (eq_mode_invalid_o),
      .input_output_route_select_o          (input_output_route_select_o),
      .first_serial_output_en_o             (first_serial_output_en_o),
      .second_serial_output_en_o            (second_serial_output_en_o)
   );
   task automatic chk(input logic [7:0] g, e);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1;
      chk({7'h00, reg_rvalid_o}, 8'h01);
      chk(reg_rdata_o, e);
   endtask
   task automatic s_reset;
      chk({6'h00, boost_override_enable_o, first_serial_output_en_o}, 8'h03);
      chk(eq_stage_boost_o, 8'h80);
      rd(8'h14, 8'h00);
      rd(8'h15, 8'h00);
      rd(8'h2d, 8'h88);
      rd(8'h31, 8'h00);
      rd(8'h20, 8'h00);
   endtask
   task automatic s_thr;
      logic [3:0] code [5] = '{4'h0, 4'h5, 4'ha, 4'hf, 4'h6};
      for (int i = 0; i < 5; i++) begin
         wr(8'h14, {2'h0, code[i], 2'h0});
         wr(8'h15, {2'h0, code[4 - i], 2'h0});
         chk({first_input_assert_level_select_o, first_input_deassert_level_select_o}, code[i]);
         chk({second_input_assert_level_select_o, second_input_deassert_level_select_o}, code[4 - i]);
         chk({5'h00, first_input_level_o}, 8'(i));
         chk({5'h00, second_input_level_o}, 8'(4 - i));
         rd(8'h15, {2'h0, code[4 - i], 2'h0});
      end
   endtask
   task automatic s_ovr;
      wr(8'h03, 8'h5a);
      chk(eq_stage_boost_o, 8'h5a);
      wr(8'h2d, 8'h80);
      @(posedge clk_i);
      #1;
      chk({7'h00, boost_override_enable_o}, 8'h00);
      chk(eq_stage_boost_o, 8'h3c);
      @(posedge clk_i);
      eq_adapt_boost_i <= 8'hc3;
      @(posedge clk_i);
      #1;
      chk(eq_stage_boost_o, 8'hc3);
      rd(8'h2d, 8'h80);
      wr(8'h2d, 8'h88);
      @(posedge clk_i);
      #1;
      chk(eq_stage_boost_o, 8'h5a);
   endtask
   task automatic s_mode;
      for (int k = 0; k < 4; k++) begin
         wr(8'h31, {1'b0, 2'(k % 2), 3'h0, 2'(k)});
         chk({6'h00, eq_test_mode_o, eq_mode_invalid_o}, {6'h00, k % 2 == 1, 1'b0});
         chk({6'h00, eq_mode_o}, 8'(k % 2));
         chk({5'h00, rt}, {5'h00, k > 1, k != 2, k != 1});
         rd(8'h31, {1'b0, 2'(k % 2), 3'h0, 2'(k)});
      end
   endtask
   task automatic s_rst2;
      wr(8'h2d, 8'h80);
      wr(8'h20, 8'hff);
      rd(8'h20, 8'h00);
      @(posedge clk_i);
      reset_i <= 1'b1;
      @(posedge clk_i);
      reset_i <= 1'b0;
      #1;
      chk({7'h00, boost_override_enable_o}, 8'h01);
      chk(eq_stage_boost_o, 8'h80);
      rd(8'h2d, 8'h88);
   endtask
   task automatic results;
      if (n_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      #1;
      s_reset();
      s_thr();
      s_ovr();
      s_mode();
      s_rst2();
      results();
   end
   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      results();
   end
endmodule
bind rxcfg_regs rxcfg_regs_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_rxcfg_regs_checker (.*);
